// >>> rtl/ssoc_top.sv
// The APB slave port and the address map were left to the implementer.
module ssoc_top #(
   parameter int SYNC_MAX = ssoc_pkg::SYNC_MAX_CYC,
   parameter int ACT_WIN = ssoc_pkg::ACT_WIN_CYC,
   parameter int DIV_W = 16
) (
   input wire logic ref_clk,
   input wire logic reset,
   input ssoc_pkg::ssoc_apb_req_t apb_req,
   output ssoc_pkg::ssoc_apb_rsp_t apb_rsp,
   input wire logic supplies_ok,
   input wire logic config_done,
   input wire logic pll_lock,
   input wire logic enable_pin,
   input wire logic [2:0] mon_clk,
   output ssoc_pkg::ssoc_cfg_t cfg,
   output ssoc_pkg::ssoc_pins_t pins,
   output logic lock_gpio
);
   import ssoc_pkg::*;

   localparam int SW = $clog2(SYNC_MAX + 1);
   localparam int AW = $clog2(ACT_WIN + 1);

   // ************************************************************
   // State
   // ************************************************************
   typedef enum logic [2:0] {PH_PWR, PH_LOAD, PH_SYNC, PH_LOCKWAIT, PH_RUN} ssoc_phase_t;

   typedef struct packed {
      ssoc_apb_rsp_t rsp;
      ssoc_cfg_t cfg;
      ssoc_pins_t pins;
      logic gpio;
      logic oe_sel;
      logic start_imm;
      logic gpio_sel;
      logic lol;
      logic lock_q;
      logic started;
      logic [NOUT-1:0][7:0] ocfg;
      logic [NOUT-1:0][DIV_W-1:0] ratio;
      logic [NOUT-1:0][DIV_W-1:0] dcnt;
      logic [NOUT-1:0] dclk;
      logic [NOUT-1:0] gate;
      ssoc_phase_t phase;
      logic [SW-1:0] scnt;
      logic [31:0] los_cfg;
      logic [7:0] los_times;
      logic [23:0] act_nom;
      logic [31:0] act_marg;
      logic [2:0] mon_q;
      logic [2:0][15:0] lcnt;
      logic [2:0][3:0] lfail;
      logic [2:0][3:0] lgood;
      logic [2:0] los_sts;
      logic [AW-1:0] wcnt;
      logic [1:0][23:0] ecnt;
      logic [1:0] act_sts;
   } ssoc_state_t;

   ssoc_state_t s;
   ssoc_state_t n;

   logic acc;
   logic wr;
   logic hit;
   logic sync_req;
   logic sync_done;
   logic edg;
   logic tmo;
   logic wend;
   logic [1:0] jd;
   logic [31:0] rd;
   logic [NOUT-1:0] pd;
   logic [NOUT-1:0] want;
   logic [DIV_W-1:0] r;
   logic [15:0] los_nom;
   logic [7:0] los_acc;
   logic [7:0] los_rej;
   logic [15:0] act_acc;
   logic [15:0] act_rej;

   function automatic ssoc_state_t rst_state();
      ssoc_state_t x;
      x = '0;
      x.cfg.fb_int = R_FBINT;
      for (int i = 0; i < NOUT; i++) begin
         x.ratio[i] = DIV_W'(R_DIV);
      end
      x.los_cfg = R_LOSCFG;
      x.los_times = R_LOSTIM;
      x.act_nom = R_ACTNOM;
      x.act_marg = R_ACTMRG;
      return x;
   endfunction

   // Returns {out of reject band, inside accept band}
   function automatic logic [1:0] judge(
      input logic [23:0] m,
      input logic [23:0] nom,
      input logic [23:0] am,
      input logic [23:0] rm
   );
      logic [23:0] d;
      d = (m > nom) ? m - nom : nom - m;
      return {d > rm, d <= am};
   endfunction

   assign los_nom = s.los_cfg[L_NOM +: 16];
   assign los_acc = s.los_cfg[L_ACC +: 8];
   assign los_rej = s.los_cfg[L_REJ +: 8];
   assign act_acc = s.act_marg[G_ACC +: 16];
   assign act_rej = s.act_marg[G_REJ +: 16];

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      n = s;
      edg = 1'b0;
      tmo = 1'b0;
      jd = 2'b00;
      r = '0;
      sync_req = 1'b0;
      sync_done = 1'b0;
      // APB slave: answer one cycle into the access phase
      acc = apb_req.psel & apb_req.penable;
      hit = 1'b1;
      rd = '0;
      case (apb_req.paddr)
         A_CTRL: begin
            rd[C_INBUF] = s.cfg.inbuf_en;
            rd[C_SE] = s.cfg.single_ended;
            rd[C_BIAS] = s.cfg.bias_en;
            rd[C_REFSEL] = s.cfg.ref_sel;
            rd[C_DBL] = s.cfg.doubler_en;
            rd[C_P3] = s.cfg.p3_bypass;
            rd[C_OESEL] = s.oe_sel;
            rd[C_STIMM] = s.start_imm;
            rd[C_GPIO] = s.gpio_sel;
         end
         A_STAT: begin
            rd[S_LOCK] = s.lock_q;
            rd[S_LOL] = s.lol;
            rd[S_LOS +: 3] = s.los_sts;
            rd[S_ACT +: 2] = s.act_sts;
            rd[S_BUSY] = s.phase == PH_SYNC;
            rd[S_RUN] = s.started;
         end
         A_FBINT: rd[FBI_W-1:0] = s.cfg.fb_int;
         A_FBFRAC: rd[FRAC_W-1:0] = s.cfg.fb_frac;
         A_DCO: rd = s.cfg.dco_offset;
         A_OCFG: rd = s.ocfg;
         A_DIV0: rd[DIV_W-1:0] = s.ratio[0];
         A_DIV1: rd[DIV_W-1:0] = s.ratio[1];
         A_DIV2: rd[DIV_W-1:0] = s.ratio[2];
         A_DIV3: rd[DIV_W-1:0] = s.ratio[3];
         A_LOSCFG: rd = s.los_cfg;
         A_LOSTIM: rd[7:0] = s.los_times;
         A_ACTNOM: rd[23:0] = s.act_nom;
         A_ACTMRG: rd = s.act_marg;
         default: hit = 1'b0;
      endcase
      n.rsp.pready = acc & ~s.rsp.pready;
      n.rsp.pslverr = acc & ~s.rsp.pready & ~hit;
      if (acc & ~s.rsp.pready) begin
         n.rsp.prdata = apb_req.pwrite ? 32'h0 : rd;
      end
      // Writes land on the edge that completes the transfer
      wr = acc & s.rsp.pready & apb_req.pwrite & hit;
      if (wr) begin
         case (apb_req.paddr)
            A_CTRL: begin
               n.cfg.inbuf_en = apb_req.pwdata[C_INBUF];
               n.cfg.single_ended = apb_req.pwdata[C_SE];
               n.cfg.bias_en = apb_req.pwdata[C_BIAS];
               n.cfg.ref_sel = apb_req.pwdata[C_REFSEL];
               n.cfg.doubler_en = apb_req.pwdata[C_DBL];
               n.cfg.p3_bypass = apb_req.pwdata[C_P3];
               n.oe_sel = apb_req.pwdata[C_OESEL];
               n.start_imm = apb_req.pwdata[C_STIMM];
               n.gpio_sel = apb_req.pwdata[C_GPIO];
               sync_req = apb_req.pwdata[C_SYNC];
            end
            A_STAT: begin
               if (apb_req.pwdata[S_LOL]) begin
                  n.lol = 1'b0;
               end
            end
            A_FBINT: n.cfg.fb_int = apb_req.pwdata[FBI_W-1:0];
            A_FBFRAC: n.cfg.fb_frac = apb_req.pwdata[FRAC_W-1:0];
            A_DCO: n.cfg.dco_offset = apb_req.pwdata;
            A_OCFG: n.ocfg = apb_req.pwdata;
            A_DIV0: n.ratio[0] = apb_req.pwdata[DIV_W-1:0];
            A_DIV1: n.ratio[1] = apb_req.pwdata[DIV_W-1:0];
            A_DIV2: n.ratio[2] = apb_req.pwdata[DIV_W-1:0];
            A_DIV3: n.ratio[3] = apb_req.pwdata[DIV_W-1:0];
            A_LOSCFG: n.los_cfg = apb_req.pwdata;
            A_LOSTIM: n.los_times = apb_req.pwdata[7:0];
            A_ACTNOM: n.act_nom = apb_req.pwdata[23:0];
            A_ACTMRG: n.act_marg = apb_req.pwdata;
            default: n.lol = s.lol;
         endcase
      end

      // ************************************************************
      // Lock tracking
      // ************************************************************
      n.lock_q = pll_lock;
      // Placed after the clear so a coincident fall is kept
      if (s.lock_q & ~pll_lock) begin
         n.lol = 1'b1;
      end
      n.gpio = s.gpio_sel & pll_lock;

      // ************************************************************
      // Start-up and divider sync
      // ************************************************************
      // Compared at full width: the minimum may exceed a short counter
      sync_done = ((32'(s.scnt) >= 32'(SYNC_MIN_CYC)) & pll_lock)
         | (s.scnt >= SW'(SYNC_MAX - 1));
      case (s.phase)
         PH_PWR: begin
            if (supplies_ok) begin
               n.phase = PH_LOAD;
            end
         end
         PH_LOAD: begin
            if (config_done) begin
               n.phase = PH_SYNC;
               n.scnt = '0;
            end
         end
         PH_SYNC: begin
            n.scnt = s.scnt + SW'(1);
            if (sync_done) begin
               if (s.started | s.start_imm) begin
                  n.phase = PH_RUN;
                  n.started = 1'b1;
               end else begin
                  n.phase = PH_LOCKWAIT;
               end
            end
         end
         PH_LOCKWAIT: begin
            if (pll_lock) begin
               n.phase = PH_RUN;
               n.started = 1'b1;
            end
         end
         PH_RUN: n.phase = PH_RUN;
         default: n.phase = PH_PWR;
      endcase
      // Manual resync; its gap shows on enabled outputs
      if (sync_req & (s.phase == PH_RUN || s.phase == PH_LOCKWAIT)) begin
         n.phase = PH_SYNC;
         n.scnt = '0;
      end

      // ************************************************************
      // Output dividers, gates and drivers
      // ************************************************************
      for (int i = 0; i < NOUT; i++) begin
         pd[i] = s.ocfg[i][O_PD];
         want[i] = (s.phase == PH_RUN) & ~pd[i] & ~s.ocfg[i][O_OFF]
            & (s.oe_sel | enable_pin);
         // Next phase, so a sync stops the dividers on its first cycle
         if (n.phase == PH_RUN || n.phase == PH_LOCKWAIT) begin
            r = (s.ratio[i] < DIV_W'(2)) ? DIV_W'(2) : s.ratio[i];
            n.dcnt[i] = (s.dcnt[i] >= r - DIV_W'(1)) ? '0 : s.dcnt[i] + DIV_W'(1);
            n.dclk[i] = n.dcnt[i] < (r >> 1);
         end else begin
            n.dcnt[i] = '0;
            n.dclk[i] = 1'b0;
         end
         // Only while low, so every high pulse is whole
         if (~s.dclk[i]) begin
            n.gate[i] = want[i];
         end
         if (s.phase == PH_PWR || pd[i]) begin
            n.pins.out_oe[i] = 1'b0;
            n.pins.out_p[i] = 1'b0;
            n.pins.out_n[i] = 1'b0;
         end else if (n.gate[i]) begin
            n.pins.out_oe[i] = 1'b1;
            n.pins.out_p[i] = n.dclk[i];
            if (s.ocfg[i][O_MODE +: 2] == M_CMOS) begin
               n.pins.out_n[i] = s.ocfg[i][O_BOTH] & n.dclk[i];
            end else begin
               n.pins.out_n[i] = ~n.dclk[i];
            end
         end else begin
            case (s.ocfg[i][O_DIS +: 2])
               D_HIGH: begin
                  n.pins.out_oe[i] = 1'b1;
                  n.pins.out_p[i] = 1'b1;
                  n.pins.out_n[i] = 1'b1;
               end
               D_HIZ: begin
                  n.pins.out_oe[i] = 1'b0;
                  n.pins.out_p[i] = 1'b0;
                  n.pins.out_n[i] = 1'b0;
               end
               default: begin
                  n.pins.out_oe[i] = 1'b1;
                  n.pins.out_p[i] = 1'b0;
                  n.pins.out_n[i] = 1'b0;
               end
            endcase
         end
      end

      // ************************************************************
      // Loss-of-signal monitors: ref 0, ref 1, crystal
      // ************************************************************
      n.mon_q = mon_clk;
      for (int i = 0; i < 3; i++) begin
         edg = mon_clk[i] & ~s.mon_q[i];
         // Missing edges are judged without waiting forever
         tmo = {1'b0, s.lcnt[i]} > ({1'b0, los_nom} + {9'h0, los_rej});
         jd = judge({8'h0, s.lcnt[i]}, {8'h0, los_nom}, {16'h0, los_acc},
            {16'h0, los_rej});
         if (edg | tmo) begin
            n.lcnt[i] = 16'h1;
            if (jd[1]) begin
               n.lgood[i] = 4'h0;
               if (s.lfail[i] != 4'hf) begin
                  n.lfail[i] = s.lfail[i] + 4'h1;
               end
            end else if (jd[0]) begin
               n.lfail[i] = 4'h0;
               if (s.lgood[i] != 4'hf) begin
                  n.lgood[i] = s.lgood[i] + 4'h1;
               end
            end
         end else if (s.lcnt[i] != 16'hffff) begin
            n.lcnt[i] = s.lcnt[i] + 16'h1;
         end
         if (n.lfail[i] != 4'h0 && n.lfail[i] >= s.los_times[T_FAIL +: 4]) begin
            n.los_sts[i] = 1'b1;
         end else if (n.lgood[i] != 4'h0 && n.lgood[i] >= s.los_times[T_GOOD +: 4]) begin
            n.los_sts[i] = 1'b0;
         end
      end

      // ************************************************************
      // Activity monitors on the two reference inputs
      // ************************************************************
      wend = s.wcnt == AW'(ACT_WIN - 1);
      n.wcnt = wend ? '0 : s.wcnt + AW'(1);
      for (int i = 0; i < 2; i++) begin
         edg = mon_clk[i] & ~s.mon_q[i];
         jd = judge(s.ecnt[i], s.act_nom, {8'h0, act_acc}, {8'h0, act_rej});
         if (wend) begin
            n.ecnt[i] = {23'h0, edg};
            // Fail and good thresholds are both one here
            if (jd[1]) begin
               n.act_sts[i] = 1'b1;
            end else if (jd[0]) begin
               n.act_sts[i] = 1'b0;
            end
         end else if (edg && s.ecnt[i] != 24'hff_ffff) begin
            n.ecnt[i] = s.ecnt[i] + 24'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s <= rst_state();
      end else begin
         s <= n;
      end
   end

   assign apb_rsp = s.rsp;
   assign cfg = s.cfg;
   assign pins = s.pins;
   assign lock_gpio = s.gpio;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence lock_fall;
      s.lock_q && !pll_lock;
   endsequence

   sequence sync_entry;
      s.phase != PH_SYNC ##1 s.phase == PH_SYNC;
   endsequence

   AST_INBUF_ONLY_BY_WRITE: assert property (
      $rose(cfg.inbuf_en) |-> $past(wr && apb_req.paddr == A_CTRL))
      else $error("input buffer enabled without a write");

   AST_REFSEL_BY_WRITE: assert property (
      $changed(cfg.ref_sel) || $changed(cfg.doubler_en)
      |-> $past(wr && apb_req.paddr == A_CTRL))
      else $error("doubler setup changed without a write");

   AST_LOCK_TO_GPIO: assert property (
      s.gpio_sel && pll_lock && $past(s.gpio_sel) |=> lock_gpio)
      else $error("lock not routed to gpio");

   AST_LOL_STICKY: assert property (
      lock_fall |=> s.lol ##1 (s.lol || $past(wr && apb_req.paddr == A_STAT)))
      else $error("loss-of-lock event lost");

   AST_SYNC_MIN_GAP: assert property (
      sync_entry |-> (s.phase == PH_SYNC && s.dclk == '0) [*8])
      else $error("sync gap ended too early");

   AST_SYNC_BOUND: assert property (
      s.phase == PH_SYNC |-> s.scnt < SW'(SYNC_MAX))
      else $error("sync gap over its limit");

   AST_PD_TRISTATE: assert property (
      1'b1 |=> (pins.out_oe & $past(pd)) == '0)
      else $error("powered-down output driven");

   AST_PWR_TRISTATE: assert property (
      s.phase == PH_PWR |=> pins.out_oe == '0)
      else $error("outputs driven before supplies settle");

   AST_LOCKWAIT_GATED: assert property (
      s.phase == PH_LOCKWAIT |-> s.gate == '0)
      else $error("output enabled before first lock");

   AST_GATE_IN_LOW: assert property (
      $changed(s.gate[0]) |-> !$past(s.dclk[0]))
      else $error("gate moved during high phase");
endmodule

// >>> rtl/ssoc_pkg.sv
package ssoc_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_NS = 25;
   localparam int SYNC_MIN_NS = 50000;
   localparam int SYNC_MAX_NS = 300000;
   localparam int ACT_WIN_NS = 10000000;
   localparam int SYNC_MIN_CYC = (SYNC_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_MAX_CYC = SYNC_MAX_NS / CLK_NS;
   localparam int ACT_WIN_CYC = ACT_WIN_NS / CLK_NS;
   localparam int FRAC_W = 27;
   localparam int FBI_W = 16;
   localparam int NOUT = 4;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_FBINT = 8'h08;
   localparam logic [7:0] A_FBFRAC = 8'h0c;
   localparam logic [7:0] A_DCO = 8'h10;
   localparam logic [7:0] A_OCFG = 8'h14;
   localparam logic [7:0] A_DIV0 = 8'h18;
   localparam logic [7:0] A_DIV1 = 8'h1c;
   localparam logic [7:0] A_DIV2 = 8'h20;
   localparam logic [7:0] A_DIV3 = 8'h24;
   localparam logic [7:0] A_LOSCFG = 8'h28;
   localparam logic [7:0] A_LOSTIM = 8'h2c;
   localparam logic [7:0] A_ACTNOM = 8'h30;
   localparam logic [7:0] A_ACTMRG = 8'h34;

   localparam int C_INBUF = 0;
   localparam int C_SE = 1;
   localparam int C_BIAS = 2;
   localparam int C_REFSEL = 3;
   localparam int C_DBL = 4;
   localparam int C_P3 = 5;
   localparam int C_OESEL = 6;
   localparam int C_STIMM = 7;
   localparam int C_GPIO = 8;
   localparam int C_SYNC = 9;

   localparam int S_LOCK = 0;
   localparam int S_LOL = 1;
   localparam int S_LOS = 2;
   localparam int S_ACT = 5;
   localparam int S_BUSY = 7;
   localparam int S_RUN = 8;

   localparam int O_MODE = 0;
   localparam int O_BOTH = 2;
   localparam int O_DIS = 3;
   localparam int O_PD = 5;
   localparam int O_OFF = 6;

   localparam int L_NOM = 0;
   localparam int L_ACC = 16;
   localparam int L_REJ = 24;
   localparam int T_FAIL = 0;
   localparam int T_GOOD = 4;
   localparam int G_ACC = 0;
   localparam int G_REJ = 16;

   localparam logic [1:0] M_HCSL = 2'h0;
   localparam logic [1:0] M_LVDS = 2'h1;
   localparam logic [1:0] M_CMOS = 2'h2;
   localparam logic [1:0] D_LOW = 2'h0;
   localparam logic [1:0] D_HIGH = 2'h1;
   localparam logic [1:0] D_HIZ = 2'h2;

   localparam logic [15:0] R_FBINT = 16'h0064;
   localparam logic [15:0] R_DIV = 16'h0004;
   localparam logic [31:0] R_LOSCFG = 32'h0402_0010;
   localparam logic [7:0] R_LOSTIM = 8'h33;
   localparam logic [23:0] R_ACTNOM = 24'h0f_4240;
   localparam logic [31:0] R_ACTMRG = 32'h0010_0008;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } ssoc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ssoc_apb_rsp_t;

   typedef struct packed {
      logic inbuf_en;
      logic single_ended;
      logic bias_en;
      logic ref_sel;
      logic doubler_en;
      logic p3_bypass;
      logic [FBI_W-1:0] fb_int;
      logic [FRAC_W-1:0] fb_frac;
      logic [31:0] dco_offset;
   } ssoc_cfg_t;

   typedef struct packed {
      logic [NOUT-1:0] out_p;
      logic [NOUT-1:0] out_n;
      logic [NOUT-1:0] out_oe;
   } ssoc_pins_t;
endpackage

// >>> verif/ssoc_far_model.sv
module ssoc_far_model (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic lock_req,
   output logic pll_lock,
   output logic [2:0] mon_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] lag;
   logic [4:0] div;
   // Relock takes a few cycles, loss is seen at once
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lag <= 4'h0;
         div <= 5'h00;
      end else begin
         lag <= lock_req ? {lag[2:0], 1'b1} : 4'h0;
         div <= div + 5'h01;
      end
   end
   assign pll_lock = lag[3];
   assign mon_clk = {div[4], div[3], div[2]};
endmodule

// >>> verif/synth_output_control_tb.sv
module synth_output_control_tb import ssoc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic supplies_ok = 1'b0;
   logic config_done = 1'b0;
   logic lock_req = 1'b0;
   logic enable_pin = 1'b1;
   logic pll_lock;
   logic lock_gpio;
   logic [2:0] mon_clk;
   ssoc_apb_req_t req = '0;
   ssoc_apb_rsp_t rsp;
   ssoc_cfg_t cfg;
   ssoc_pins_t pins;
   int miscompares = 0;
   int num_checks = 0;
   logic [31:0] rd;
   logic [31:0] c;
   logic err;

   always #12.5 ref_clk = ~ref_clk;

   ssoc_top #(.SYNC_MAX(64), .ACT_WIN(200)) ssoc_top_i (.ref_clk(ref_clk), .reset(reset),
      .apb_req(req), .apb_rsp(rsp), .supplies_ok(supplies_ok), .config_done(config_done),
      .pll_lock(pll_lock), .enable_pin(enable_pin), .mon_clk(mon_clk), .cfg(cfg),
      .pins(pins), .lock_gpio(lock_gpio));
   ssoc_far_model ssoc_far_model_i (.ref_clk(ref_clk), .reset(reset), .lock_req(lock_req),
      .pll_lock(pll_lock), .mon_clk(mon_clk));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      req.psel <= 1'b1;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge ref_clk);
      req.penable <= 1'b1;
      // Request held until the edge at which pready is seen high
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (rsp.pready === 1'b1) break;
      end
      if (n == 20) begin
         miscompares++;
         stop_test();
      end else begin
         rd = rsp.prdata;
         err = rsp.pslverr;
         req.psel <= 1'b0;
         req.penable <= 1'b0;
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask

   task automatic wait_bit(input int b, input logic v);
      int n;
      for (n = 0; n < 1000; n++) begin
         apb(1'b0, A_STAT, 32'h0);
         if (rd[b] === v) break;
      end
      if (n == 1000) begin
         miscompares++;
         stop_test();
      end
   endtask

   // Window lengths are whole periods, so the count is phase independent
   task automatic cnt(input int n, input int i, input logic neg, output logic [31:0] k);
      k = 32'h0;
      repeat (n) begin
         @(negedge ref_clk);
         k = k + 32'(neg ? pins.out_n[i] : pins.out_p[i]);
      end
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      cyc(12);
      reset <= 1'b0;
      cyc(2);
      chk("oe at power", pins.out_oe, 32'h0);
      chk("inbuf", cfg.inbuf_en, 32'h0);
      rc(A_CTRL, 32'h0, "ctrl");
      rc(A_FBINT, 32'h64, "fbint");
      rc(A_DIV0, 32'h4, "div0");
      rc(A_LOSCFG, 32'h0402_0010, "loscfg");
      rc(A_LOSTIM, 32'h33, "lostim");
      rc(A_ACTNOM, 32'h000f_4240, "actnom");
      rc(A_ACTMRG, 32'h0010_0008, "actmrg");
      apb(1'b0, 8'h38, 32'h0);
      chk("unmapped err", err, 32'h1);
      chk("unmapped data", rd, 32'h0);
      // Bypass kept off: a non-zero fraction follows
      apb(1'b1, A_CTRL, 32'h1f);
      cyc(1);
      chk("cfg", {cfg.doubler_en, cfg.ref_sel, cfg.bias_en, cfg.single_ended,
         cfg.inbuf_en}, 5'h1f);
      // Nominal 16 keeps the window above 8 clocks
      apb(1'b1, A_LOSCFG, 32'h0402_0010);
      apb(1'b1, A_ACTNOM, 32'h19);
      apb(1'b1, A_ACTMRG, 32'h0002_0001);
      cyc(450);
      apb(1'b0, A_STAT, 32'h0);
      chk("los sts", rd[S_LOS +: 3], 32'h5);
      chk("act sts", rd[S_ACT +: 2], 32'h2);
      apb(1'b1, A_FBFRAC, 32'hffff_ffff);
      rc(A_FBFRAC, 32'h07ff_ffff, "fraction");
      chk("fraction cfg", cfg.fb_frac, 32'h07ff_ffff);
      apb(1'b1, A_DCO, 32'h1234_5678);
      rc(A_DCO, 32'h1234_5678, "dco");
      chk("dco cfg", cfg.dco_offset, 32'h1234_5678);
      apb(1'b1, A_DIV1, 32'h6);
      apb(1'b1, A_OCFG, 32'h0220_0000);
      supplies_ok <= 1'b1;
      cyc(5);
      chk("oe powered", pins.out_oe, 32'hb);
      chk("low", {pins.out_p & 4'hb, pins.out_n & 4'hb}, 32'h0);
      config_done <= 1'b1;
      cyc(150);
      apb(1'b0, A_STAT, 32'h0);
      chk("lock wait", rd[S_RUN], 32'h0);
      lock_req <= 1'b1;
      wait_bit(S_RUN, 1'b1);
      cnt(120, 0, 1'b0, c);
      chk("div0 highs", c, 32'd60);
      cnt(120, 1, 1'b0, c);
      chk("div1 highs", c, 32'd60);
      cnt(120, 3, 1'b1, c);
      chk("cmos single", c, 32'h0);
      cnt(120, 3, 1'b0, c);
      chk("cmos p", c, 32'd60);
      apb(1'b1, A_CTRL, 32'h100);
      cyc(3);
      chk("gpio", lock_gpio, 32'h1);
      lock_req <= 1'b0;
      cyc(4);
      chk("gpio off", lock_gpio, 32'h0);
      apb(1'b0, A_STAT, 32'h0);
      chk("lol set", rd[1:0], 32'h2);
      cnt(12, 0, 1'b0, c);
      chk("no gating", c, 32'd6);
      apb(1'b1, A_STAT, 32'h2);
      apb(1'b0, A_STAT, 32'h0);
      chk("lol clear", rd[1], 32'h0);
      lock_req <= 1'b1;
      apb(1'b1, A_CTRL, 32'h140);
      apb(1'b1, A_OCFG, 32'h1220_0048);
      cyc(10);
      chk("dis high", {pins.out_p[0], pins.out_n[0], pins.out_oe[0]}, 32'h7);
      cnt(12, 1, 1'b0, c);
      chk("other on", c, 32'd6);
      apb(1'b1, A_CTRL, 32'h100);
      enable_pin <= 1'b0;
      cyc(10);
      chk("pin off", {pins.out_p[1], pins.out_n[1], pins.out_oe[1]}, 32'h1);
      chk("hiz", pins.out_oe[3], 32'h0);
      enable_pin <= 1'b1;
      cyc(10);
      apb(1'b1, A_CTRL, 32'h300);
      cyc(20);
      cnt(24, 1, 1'b0, c);
      chk("sync gap", c, 32'h0);
      wait_bit(S_BUSY, 1'b0);
      cnt(12, 1, 1'b0, c);
      chk("resync", c, 32'd6);
      stop_test();
   end
endmodule
